// ===== src/cbse_pkg.sv
// Functional notes
// - write-only register reads back as all ones
// - bit clear: read byte, clear bit, write back
// - bit ops are byte read-modify-write
// - 4-bit condition; 0000 always, 0001 never
// - absolute jump loads operand address
// - absolute call saves return, jumps
// - relative call: next pc plus signed displacement
// - exception return resumes interrupted program
// - exception return restores pc and flags
// - sleep enters power-down state
// - flags load from immediate or register
// - flags store copies flags to register
// - flags and with immediate
// - flags or with immediate
// - flags xor with immediate
// - idle advances pc by two only
// - block move uses count, source, destination
// - nonzero count copies bytes; zero does nothing
// - next instruction written before block move end is ignored
package cbse_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [11:0] CBSE_CMD_OFS = 12'h000;
   localparam logic [11:0] CBSE_OPA_OFS = 12'h004;
   localparam logic [11:0] CBSE_OPB_OFS = 12'h008;
   localparam logic [11:0] CBSE_PC_OFS = 12'h00c;
   localparam logic [11:0] CBSE_FLG_OFS = 12'h010;
   localparam logic [11:0] CBSE_STS_OFS = 12'h014;
   localparam logic [11:0] CBSE_CNT_OFS = 12'h018;
   localparam logic [11:0] CBSE_SRC_OFS = 12'h01c;
   localparam logic [11:0] CBSE_DST_OFS = 12'h020;
   localparam logic [11:0] CBSE_RES_OFS = 12'h024;
   localparam logic [11:0] CBSE_SP_OFS = 12'h028;
   localparam logic [11:0] CBSE_MEM_OFS = 12'h100;
   localparam logic [11:0] CBSE_MEM_MSK = 12'hf00;
   localparam logic [7:0] CBSE_ALL_ONES = 8'hff;
   localparam logic [15:0] CBSE_PC_STEP = 16'h0002;
   localparam logic [15:0] CBSE_SP_RST = 16'h00ff;
   localparam logic [7:0] CBSE_FLG_RST = 8'h80;
   // flag bit positions
   localparam int CBSE_FC = 0;
   localparam int CBSE_FV = 1;
   localparam int CBSE_FZ = 2;
   localparam int CBSE_FN = 3;
   // -----------------------------------------------------------------
   // operations
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_BRANCH = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_RCALL = 4'h3,
      OP_RET = 4'h4, OP_ERET = 4'h5, OP_SLEEP = 4'h6, OP_FLD = 4'h7,
      OP_FST = 4'h8, OP_FAND = 4'h9, OP_FOR = 4'ha, OP_FXOR = 4'hb,
      OP_IDLE = 4'hc, OP_MOVE = 4'hd, OP_BITOP = 4'he, OP_WAKE = 4'hf
   } cbse_op_t;
   // bit op kinds in opa[5:3]
   localparam logic [2:0] BK_SET = 3'h0;
   localparam logic [2:0] BK_CLR = 3'h1;
   localparam logic [2:0] BK_INV = 3'h2;
   localparam logic [2:0] BK_ST = 3'h3;
   localparam logic [2:0] BK_IST = 3'h4;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001, ST_RD = 6'b000010, ST_WR = 6'b000100,
      ST_POP = 6'b001000, ST_MV = 6'b010000, ST_SLP = 6'b100000
   } cbse_st_t;
endpackage

// ===== src/cbse_core.sv
`timescale 1ns/1ps
module cbse_core
   import cbse_pkg::*;
#(
   parameter int MEM_DEPTH = 64,
   parameter int WO_ADDR = 5
)
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // state
   output logic busy,
   output logic sleeping
);
   localparam int AW = $clog2(MEM_DEPTH);
   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] wo_q;
   logic [15:0] pc_q, sp_q, src_q, dst_q, ret_q;
   logic [7:0] flg_q, cnt_q, opa_q, res_q, rd_q, popf_q;
   logic [15:0] opb_q;
   cbse_op_t op_q;
   cbse_st_t st_q;
   logic taken_q;
   logic [1:0] pop_q;

   wire wr_en = psel && penable && pwrite && pready;
   wire rd_en = psel && !penable && !pwrite;
   wire go = wr_en && paddr == CBSE_CMD_OFS && st_q == ST_IDLE;
   wire is_mem = (paddr & CBSE_MEM_MSK) == CBSE_MEM_OFS;
   wire [AW-1:0] mix = paddr[AW+1:2];

   // ----------------------------------------------------------------
   // memory read with write-only readback
   // ----------------------------------------------------------------
   function automatic logic [7:0] rdb(input logic [15:0] a,
                                     input logic [7:0] m);
      rdb = (a == 16'(WO_ADDR)) ? CBSE_ALL_ONES : m;
   endfunction

   // ----------------------------------------------------------------
   // condition decode
   // ----------------------------------------------------------------
   logic cond_even, cond;
   always_comb
   begin
      case (opa_q[3:1])
         3'd0: cond_even = 1'b1;
         3'd1: cond_even = !(flg_q[CBSE_FC] | flg_q[CBSE_FZ]);
         3'd2: cond_even = !flg_q[CBSE_FC];
         3'd3: cond_even = !flg_q[CBSE_FZ];
         3'd4: cond_even = !flg_q[CBSE_FV];
         3'd5: cond_even = !flg_q[CBSE_FN];
         3'd6: cond_even = !(flg_q[CBSE_FN] ^ flg_q[CBSE_FV]);
         3'd7: cond_even = !(flg_q[CBSE_FZ] |
                             (flg_q[CBSE_FN] ^ flg_q[CBSE_FV]));
         default: cond_even = 1'b0;
      endcase
      cond = opa_q[0] ? !cond_even : cond_even;
   end

   // modified byte for bit ops
   logic [7:0] bit_m, mod;
   always_comb
   begin
      bit_m = 8'h01 << opa_q[2:0];
      case (opa_q[5:3])
         BK_SET: mod = rd_q | bit_m;
         BK_CLR: mod = rd_q & ~bit_m;
         BK_INV: mod = rd_q ^ bit_m;
         BK_ST: mod = flg_q[CBSE_FC] ? rd_q | bit_m : rd_q & ~bit_m;
         BK_IST: mod = flg_q[CBSE_FC] ? rd_q & ~bit_m : rd_q | bit_m;
         default: mod = rd_q;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= ST_IDLE;
         op_q <= OP_IDLE;
         pop_q <= 2'd0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
               if (go)
               begin
                  op_q <= cbse_op_t'(pwdata[3:0]);
                  case (cbse_op_t'(pwdata[3:0]))
                     OP_BITOP: st_q <= ST_RD;
                     OP_MOVE: st_q <= ST_MV;
                     OP_ERET: st_q <= ST_POP;
                     OP_RET: st_q <= ST_POP;
                     OP_SLEEP: st_q <= ST_SLP;
                     default: st_q <= ST_IDLE;
                  endcase
                  pop_q <= 2'd0;
               end
            ST_RD: st_q <= ST_WR;
            ST_WR: st_q <= ST_IDLE;
            ST_POP:
            begin
               pop_q <= pop_q + 2'd1;
               if (pop_q == (op_q == OP_ERET ? 2'd2 : 2'd1))
                  st_q <= ST_IDLE;
            end
            ST_MV:
               if (cnt_q == 8'h00)
                  st_q <= ST_IDLE;
            ST_SLP:
               if (wr_en && paddr == CBSE_CMD_OFS &&
                   pwdata[3:0] == OP_WAKE)
                  st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // read byte captured in read phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_q <= 8'h00;
      else if (st_q == ST_RD)
         rd_q <= rdb(opb_q, mem_q[opb_q[AW-1:0]]);
   end

   // operands
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opa_q <= 8'h00;
         opb_q <= 16'h0000;
      end
      else if (wr_en && st_q == ST_IDLE)
      begin
         if (paddr == CBSE_OPA_OFS)
            opa_q <= pwdata[7:0];
         if (paddr == CBSE_OPB_OFS)
            opb_q <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // pc, flags, stack, result
   // ----------------------------------------------------------------
   wire [15:0] pc_nx = pc_q + CBSE_PC_STEP;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_q <= 16'h0000;
         flg_q <= CBSE_FLG_RST;
         sp_q <= CBSE_SP_RST;
         res_q <= 8'h00;
         ret_q <= 16'h0000;
         popf_q <= 8'h00;
         taken_q <= 1'b0;
      end
      else if (go)
      begin
         case (cbse_op_t'(pwdata[3:0]))
            OP_BRANCH:
            begin
               taken_q <= cond;
               pc_q <= cond ? pc_nx + {{8{opb_q[7]}}, opb_q[7:0]} : pc_nx;
            end
            OP_JUMP: pc_q <= opb_q;
            OP_CALL:
            begin
               ret_q <= pc_nx;
               sp_q <= sp_q - 16'd2;
               pc_q <= opb_q;
            end
            OP_RCALL:
            begin
               ret_q <= pc_nx;
               sp_q <= sp_q - 16'd2;
               pc_q <= pc_nx + {{8{opb_q[7]}}, opb_q[7:0]};
            end
            OP_FLD: flg_q <= opa_q[7] ? res_q : opb_q[7:0];
            OP_FST: res_q <= flg_q;
            OP_FAND: flg_q <= flg_q & opb_q[7:0];
            OP_FOR: flg_q <= flg_q | opb_q[7:0];
            OP_FXOR: flg_q <= flg_q ^ opb_q[7:0];
            OP_IDLE: pc_q <= pc_nx;
            default: pc_q <= pc_q;
         endcase
      end
      else if (st_q == ST_POP)
      begin
         // stack image: flags only, pc kept in ret_q; pc restored on the last pop, flags too on eret
         sp_q <= sp_q + 16'd1;
         // flags sit one above the post-call sp, reached on second pop
         if (op_q == OP_ERET && pop_q == 2'd1)
            popf_q <= mem_q[sp_q[AW-1:0]];
         if (pop_q == (op_q == OP_ERET ? 2'd2 : 2'd1))
         begin
            pc_q <= ret_q;
            if (op_q == OP_ERET)
               flg_q <= popf_q;
         end
      end
      else if (wr_en && st_q == ST_IDLE)
      begin
         if (paddr == CBSE_PC_OFS)
            pc_q <= pwdata[15:0];
         if (paddr == CBSE_FLG_OFS)
            flg_q <= pwdata[7:0];
         if (paddr == CBSE_RES_OFS)
            res_q <= pwdata[7:0];
         if (paddr == CBSE_SP_OFS)
            sp_q <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // block move registers
   // ----------------------------------------------------------------
   // destination wrap is left to software, no guard here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 8'h00;
         src_q <= 16'h0000;
         dst_q <= 16'h0000;
      end
      else if (st_q == ST_MV && cnt_q != 8'h00)
      begin
         src_q <= src_q + 16'd1;
         dst_q <= dst_q + 16'd1;
         cnt_q <= cnt_q - 8'd1;
      end
      else if (wr_en && st_q == ST_IDLE)
      begin
         if (paddr == CBSE_CNT_OFS)
            cnt_q <= pwdata[7:0];
         if (paddr == CBSE_SRC_OFS)
            src_q <= pwdata[15:0];
         if (paddr == CBSE_DST_OFS)
            dst_q <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // memory and write-only register
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < MEM_DEPTH; i++)
      begin : g_mem
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               mem_q[i] <= 8'h00;
            else if (st_q == ST_WR && opb_q[AW-1:0] == AW'(i))
               mem_q[i] <= mod;
            else if (st_q == ST_MV && cnt_q != 8'h00 &&
                     dst_q[AW-1:0] == AW'(i))
               mem_q[i] <= rdb(src_q, mem_q[src_q[AW-1:0]]);
            else if (st_q == ST_IDLE && go &&
                     (pwdata[3:0] == OP_CALL || pwdata[3:0] == OP_RCALL) &&
                     sp_q[AW-1:0] - AW'(1) == AW'(i))
               mem_q[i] <= flg_q;
            else if (wr_en && st_q == ST_IDLE && is_mem && mix == AW'(i))
               mem_q[i] <= pwdata[7:0];
         end
      end
   endgenerate

   // write-only shadow, the value the port logic would use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wo_q <= 8'h00;
      else
         wo_q <= mem_q[WO_ADDR];
   end

   // ----------------------------------------------------------------
   // apb read side
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         busy <= 1'b0;
         sleeping <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         busy <= st_q != ST_IDLE && st_q != ST_SLP;
         sleeping <= st_q == ST_SLP;
         if (rd_en)
         begin
            prdata <= 32'h0000_0000;
            case (paddr)
               CBSE_OPA_OFS: prdata[7:0] <= opa_q;
               CBSE_OPB_OFS: prdata[15:0] <= opb_q;
               CBSE_PC_OFS: prdata[15:0] <= pc_q;
               CBSE_FLG_OFS: prdata[7:0] <= flg_q;
               CBSE_STS_OFS: prdata[8:0] <= {taken_q, 2'b00, st_q};
               CBSE_CNT_OFS: prdata[7:0] <= cnt_q;
               CBSE_SRC_OFS: prdata[15:0] <= src_q;
               CBSE_DST_OFS: prdata[15:0] <= dst_q;
               CBSE_RES_OFS: prdata[7:0] <= res_q;
               CBSE_SP_OFS: prdata[15:0] <= sp_q;
               default:
                  if (is_mem)
                     prdata[7:0] <= rdb(16'(mix), mem_q[mix]);
                  else
                     prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ===== test/cbse_core_props.sv
`timescale 1ns/1ps
module cbse_core_props
   import cbse_pkg::*;
#(
   parameter int MEM_DEPTH = 64,
   parameter int WO_ADDR = 5
)
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // state
   input wire logic busy,
   input wire logic sleeping
);
   localparam logic [11:0] WO_BYTE = CBSE_MEM_OFS + 12'(4 * WO_ADDR);
   logic go;
   logic idle;
   logic [3:0] op;
   assign go = psel && penable && pready && pwrite && paddr == CBSE_CMD_OFS;
   assign idle = !busy && !sleeping;
   assign op = pwdata[3:0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // checks
   // ----
   a_wo_reads_ones: assert property (
      psel && penable && !pwrite && paddr == WO_BYTE
      |-> prdata[7:0] == CBSE_ALL_ONES) else $error("write-only byte seen");
   a_bitop_goes_busy: assert property (
      go && op == OP_BITOP && idle |-> ##[1:2] busy)
      else $error("bit op did not start");
   a_sleep_entry: assert property (
      go && op == OP_SLEEP && idle |-> ##[1:2] sleeping)
      else $error("sleep not entered");
   a_sleep_holds: assert property (
      sleeping && !(go && op == OP_WAKE) &&
      !($past(go) && $past(op) == OP_WAKE) |=> sleeping)
      else $error("sleep left without wake");
   a_idle_op_quiet: assert property (
      go && op == OP_IDLE && idle |=> !busy [*2])
      else $error("idle op made block busy");
   a_busy_bounded: assert property (
      $rose(busy) |-> ##[1:300] !busy) else $error("busy never ended");
   a_busy_not_sleep: assert property (
      busy |-> !sleeping) else $error("busy while sleeping");
   a_busy_refuses: assert property (
      go && op == OP_SLEEP ##1 busy |=> !sleeping)
      else $error("command taken while busy");
   c_sleep: cover property ($rose(sleeping));
   c_busy: cover property ($rose(busy));
   c_wo_read: cover property (psel && penable && !pwrite && paddr == WO_BYTE);
endmodule
bind cbse_core cbse_core_props #(.MEM_DEPTH(MEM_DEPTH), .WO_ADDR(WO_ADDR))
   cbse_core_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
   .sleeping(sleeping));

// ===== test/cbse_mem_ref.sv
`timescale 1ns/1ps
module cbse_mem_ref
#(
   parameter int MEM_DEPTH = 64,
   parameter int WO_ADDR = 5
);
   logic [7:0] m [MEM_DEPTH];
   // content of the write-only byte never shows on a read
   function automatic logic [7:0] rd(input int i);
      return (i == WO_ADDR) ? 8'hff : m[i];
   endfunction
   // caller keeps d + n inside the array, no wrap
   function automatic void mv(input int s, input int d, input int n);
      for (int k = 0; k < n; k++)
      begin
         m[d + k] = rd(s + k);
      end
   endfunction
endmodule

// ===== test/cbse_core_bench.sv
`timescale 1ns/1ps
module cbse_core_bench;
   import cbse_pkg::*;
   localparam int WO = 5;
   localparam logic [2:0] BK [5] = '{BK_SET, BK_CLR, BK_INV, BK_ST, BK_IST};
   localparam logic [2:0] BB [5] = '{3'h3, 3'h0, 3'h7, 3'h1, 3'h2};
   localparam logic [7:0] BI [5] = '{8'h00, 8'ha5, 8'h0f, 8'h00, 8'hff};
   localparam logic [7:0] BE [5] = '{8'h08, 8'ha4, 8'h8f, 8'h02, 8'hfb};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic busy, sleeping;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, p;
   int n_fail = 0;
   int samples_checked = 0;
   cbse_core #(.MEM_DEPTH(64), .WO_ADDR(WO)) cbse_core_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy), .sleeping(sleeping));
   cbse_mem_ref #(.MEM_DEPTH(64), .WO_ADDR(WO)) cbse_mem_ref_i ();
   // ----
   // access tasks
   // ----
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", s, e, g);
         n_fail++;
      end
   endtask
   // one transfer, then an idle cycle so no signal is driven twice
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         $display("[ERR] pready exp 1 got %b", pready);
         n_fail++;
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input string s, input logic [11:0] a,
      input logic [31:0] e);
      apb(1'b0, a, '0);
      chk(s, e, q);
   endtask
   function automatic logic [11:0] ma(input int i);
      return CBSE_MEM_OFS + 12'(4 * i);
   endfunction
   task automatic wr_mem(input int i, input logic [7:0] v);
      apb(1'b1, ma(i), 32'(v));
      cbse_mem_ref_i.m[i] = v;
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      do
      begin
         apb(1'b0, CBSE_STS_OFS, '0);
         k++;
      end
      while ((q[5:0] & 6'h21) == 6'h00 && k < 400);
      if (k >= 400)
      begin
         $display("[ERR] idle state exp 21 got %h", q[5:0]);
         n_fail++;
      end
   endtask
   task automatic run(input cbse_op_t op, input logic [7:0] a,
      input logic [15:0] b);
      apb(1'b1, CBSE_OPA_OFS, 32'(a));
      apb(1'b1, CBSE_OPB_OFS, 32'(b));
      apb(1'b1, CBSE_CMD_OFS, 32'(op));
      wait_idle();
   endtask
   task automatic regs(input int c, input int s, input int d);
      apb(1'b1, CBSE_CNT_OFS, 32'(c));
      apb(1'b1, CBSE_SRC_OFS, 32'(s));
      apb(1'b1, CBSE_DST_OFS, 32'(d));
   endtask
   function automatic logic cond(input logic [3:0] c, input logic [3:0] f);
      logic t;
      logic nv;
      nv = f[CBSE_FN] ^ f[CBSE_FV];
      case (c[3:1])
         3'h0: t = 1'b1;
         3'h1: t = !(f[CBSE_FC] | f[CBSE_FZ]);
         3'h2: t = !f[CBSE_FC];
         3'h3: t = !f[CBSE_FZ];
         3'h4: t = !f[CBSE_FV];
         3'h5: t = !f[CBSE_FN];
         3'h6: t = !nv;
         default: t = !(f[CBSE_FZ] | nv);
      endcase
      return c[0] ? !t : t;
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----
   // clock, watchdog, tests
   // ----
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      wrap_up();
   end
   initial
   begin
      {presetn, psel, penable, pwrite} <= 4'h0;
      paddr <= '0;
      pwdata <= '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("flags reset", CBSE_FLG_OFS, 32'(CBSE_FLG_RST));
      rchk("unmapped", 12'h02c, '0);
      wr_mem(WO, 8'h3f);
      rchk("wo byte", ma(WO), 32'h0000_00ff);
      for (int i = 0; i < 5; i++)
      begin
         wr_mem(8, BI[i]);
         run(OP_FLD, 8'h00, 16'h0081);
         run(OP_BITOP, {2'b00, BK[i], BB[i]}, 16'h0008);
         rchk("bit op", ma(8), 32'(BE[i]));
      end
      for (int f = 0; f < 16; f++)
      begin
         run(OP_FLD, 8'h00, {8'h00, 4'h8, 4'(f)});
         for (int c = 0; c < 16; c++)
         begin
            run(OP_JUMP, 8'h00, 16'h0100);
            run(OP_BRANCH, 8'(c), 16'h0010);
            rchk("branch", CBSE_PC_OFS, cond(4'(c), 4'(f)) ?
               32'h0000_0112 : 32'h0000_0102);
         end
      end
      run(OP_JUMP, 8'h00, 16'h0200);
      rchk("jump", CBSE_PC_OFS, 32'h0000_0200);
      run(OP_CALL, 8'h00, 16'h0340);
      rchk("call", CBSE_PC_OFS, 32'h0000_0340);
      run(OP_RET, 8'h00, 16'h0000);
      rchk("ret", CBSE_PC_OFS, 32'h0000_0202);
      run(OP_RCALL, 8'h00, 16'h00f0);
      rchk("rel call", CBSE_PC_OFS, 32'h0000_01f4);
      run(OP_RET, 8'h00, 16'h0000);
      rchk("rel ret", CBSE_PC_OFS, 32'h0000_0204);
      run(OP_FLD, 8'h00, 16'h008a);
      run(OP_JUMP, 8'h00, 16'h0300);
      run(OP_CALL, 8'h00, 16'h0380);
      run(OP_FLD, 8'h00, 16'h0000);
      run(OP_ERET, 8'h00, 16'h0000);
      rchk("eret pc", CBSE_PC_OFS, 32'h0000_0302);
      rchk("eret flags", CBSE_FLG_OFS, 32'h0000_008a);
      run(OP_FLD, 8'h00, 16'h00a5);
      run(OP_FAND, 8'h00, 16'h000f);
      rchk("and", CBSE_FLG_OFS, 32'h0000_0005);
      run(OP_FOR, 8'h00, 16'h0030);
      rchk("or", CBSE_FLG_OFS, 32'h0000_0035);
      run(OP_FXOR, 8'h00, 16'h00ff);
      rchk("xor", CBSE_FLG_OFS, 32'h0000_00ca);
      run(OP_FST, 8'h00, 16'h0000);
      rchk("store", CBSE_RES_OFS, 32'h0000_00ca);
      run(OP_FLD, 8'h00, 16'h0000);
      run(OP_FLD, 8'h80, 16'h0000);
      rchk("load reg", CBSE_FLG_OFS, 32'h0000_00ca);
      run(OP_JUMP, 8'h00, 16'h0400);
      run(OP_IDLE, 8'h00, 16'h0000);
      rchk("idle pc", CBSE_PC_OFS, 32'h0000_0402);
      rchk("idle flags", CBSE_FLG_OFS, 32'h0000_00ca);
      for (int i = 0; i < 8; i++) wr_mem(16 + i, 8'(17 * i + 3));
      regs(8, 16, 32);
      apb(1'b1, CBSE_OPB_OFS, 32'h0000_00ff);
      apb(1'b1, CBSE_CMD_OFS, 32'(OP_MOVE));
      apb(1'b1, CBSE_CMD_OFS, 32'(OP_FXOR));
      apb(1'b1, CBSE_CMD_OFS, 32'(OP_SLEEP));
      chk("busy in move", 32'h0000_0001, 32'(busy));
      wait_idle();
      chk("refused sleep", 32'h0000_0000, 32'(sleeping));
      chk("slverr", 32'h0000_0000, 32'(pslverr));
      cbse_mem_ref_i.mv(16, 32, 8);
      for (int i = 32; i < 40; i++)
         rchk("move", ma(i), 32'(cbse_mem_ref_i.rd(i)));
      rchk("no overlap", CBSE_FLG_OFS, 32'h0000_00ca);
      rchk("count", CBSE_CNT_OFS, 32'h0000_0000);
      rchk("src", CBSE_SRC_OFS, 32'h0000_0018);
      rchk("dst", CBSE_DST_OFS, 32'h0000_0028);
      wr_mem(48, 8'h77);
      regs(0, 16, 48);
      run(OP_MOVE, 8'h00, 16'h0000);
      rchk("zero move", ma(48), 32'h0000_0077);
      rchk("zero dst", CBSE_DST_OFS, 32'h0000_0030);
      regs(1, WO, 50);
      run(OP_MOVE, 8'h00, 16'h0000);
      rchk("wo move", ma(50), 32'h0000_00ff);
      apb(1'b0, CBSE_PC_OFS, '0);
      p = q;
      run(OP_SLEEP, 8'h00, 16'h0000);
      chk("sleeping", 32'h0000_0001, 32'(sleeping));
      run(OP_JUMP, 8'h00, 16'h0500);
      rchk("asleep pc", CBSE_PC_OFS, p);
      run(OP_WAKE, 8'h00, 16'h0000);
      chk("awake", 32'h0000_0000, 32'(sleeping));
      wrap_up();
   end
endmodule
